// ==== hdl/fsk_params.svh ====
// offsets, field positions, reset values and counts for the fsk deviation link
// Functional notes
// [R1] one numerator step moves output one minimum step
// [R2] controller computes positive step count from deviation
// [R3] negative deviation is two's complement, read signed
// [R4] eight deviation entries per profile, index 0..7
// [R5] pin mode: select bits 00, profile enabled
// [R6] pin symbol selects entry of same index
// [R7] index mode: select bits 01, profile enabled
// [R8] written index selects entry of that index
// [R9] pin and index modes: at most eight levels
// [R10] arbitrary levels only via fast or stream
// [R11] fast mode applies written signed step directly
// [R12] fast mode: select bits 11, profile enabled
// [R13] stream mode: serial words on pin 1, bits 10
// [R14] profile select picks active frequency profile
// [R15] profile select 0 first profile, 1 second
// [R16] fast and stream steps sign-extended 16-bit words
// [R17] profile disabled: zero deviation, nominal numerator
`ifndef FSK_PARAMS_SVH
`define FSK_PARAMS_SVH

// device register indices on the serial link
`define DEV_CFG_IDX        6'h00
`define DEV_INDEX_IDX      6'h01
`define DEV_FAST_IDX       6'h02
`define DEV_NOM_A_LO_IDX   6'h03
`define DEV_NOM_A_HI_IDX   6'h04
`define DEV_NOM_B_LO_IDX   6'h05
`define DEV_NOM_B_HI_IDX   6'h06
`define DEV_ENTRY_A_GRP    3'h1
`define DEV_ENTRY_B_GRP    3'h2

// device configuration word fields
`define CFG_SEL_LO         0
`define CFG_SEL_HI         1
`define CFG_LEVEL_LSB      2
`define CFG_LEVEL_MSB      3
`define CFG_EN_A           4
`define CFG_EN_B           5
`define CFG_PROFILE        6
`define CFG_RESET          16'h0000

// symbol level field codes
`define LEVEL_TWO          2'h1
`define LEVEL_FOUR         2'h2
`define LEVEL_EIGHT        2'h3

// serial frame: 2 spare, 6 address, 16 data bits, msb first
`define FRAME_BITS         5'h18
`define STREAM_BITS        5'h10

// controller register byte offsets on axi4-lite
`define CTL_CMD_OFS        4'h0
`define CTL_SYM_OFS        4'h4
`define CTL_STREAM_OFS     4'h8
`define CTL_STATUS_OFS     4'hc

`endif

// ==== hdl/fsk_pkg.sv ====
// types shared by both ends of the fsk deviation link
package fsk_pkg;

    // {mod_source_sel_hi, mod_source_sel_lo}
    typedef enum logic [1:0] {
        MODE_PIN    = 2'h0,
        MODE_INDEX  = 2'h1,
        MODE_STREAM = 2'h2,
        MODE_FAST   = 2'h3
    } mode_t;

    typedef enum logic [2:0] {
        ENG_IDLE  = 3'h1,
        ENG_SHIFT = 3'h2,
        ENG_END   = 3'h4
    } eng_state_t;

    // pin bundle order: {frame_n, serial_data, pin2, pin1, pin0}
    typedef struct packed {
        logic [4:0]              pin_m;
        logic [4:0]              pin_s;
        logic                    frame_prev;
        logic                    ws_prev;
        logic [23:0]             shift;
        logic [4:0]              bitcnt;
        logic [15:0]             sshift;
        logic [15:0]             cfg;
        logic [2:0]              index;
        logic [15:0]             fast;
        logic [15:0]             stream;
        logic [1:0][23:0]        nom;
        logic [1:0][7:0][15:0]   entry;
        logic [15:0]             dev;
        logic [23:0]             numer;
    } dev_state_t;

    typedef struct packed {
        logic                    aw_have;
        logic [3:0]              awaddr;
        logic                    w_have;
        logic [31:0]             wdata;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic                    link_clk;
        logic                    frame_n;
        logic                    sdata;
        logic                    ws;
        logic [2:0]              sym;
        eng_state_t              state;
        logic                    pend;
        logic                    is_stream;
        logic [23:0]             shift;
        logic [4:0]              cnt;
        logic [21:0]             last_cmd;
    } ctl_state_t;

endpackage : fsk_pkg

// ==== hdl/fsk_link_if.sv ====
// link between the baseband controller and the deviation selector
`timescale 1ns/1ps
`default_nettype none
interface fsk_link_if;
    logic link_clk;
    logic frame_n;
    logic serial_data;
    logic symbol_pin_0;
    logic symbol_pin_1;
    logic symbol_pin_2;

    modport ctrl (
        output link_clk,
        output frame_n,
        output serial_data,
        output symbol_pin_0,
        output symbol_pin_1,
        output symbol_pin_2
    );

    modport dev (
        input link_clk,
        input frame_n,
        input serial_data,
        input symbol_pin_0,
        input symbol_pin_1,
        input symbol_pin_2
    );
endinterface : fsk_link_if
`default_nettype wire

// ==== hdl/fsk_deviation_selector.sv ====
// device end: deviation registers, source selection and numerator update
`include "fsk_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fsk_deviation_selector (
    fsk_link_if.dev           link,
    input  wire logic         aresetn,
    output logic [23:0]       frac_numerator,
    output logic [15:0]       deviation_step,
    output logic              active_profile
);

    fsk_pkg::dev_state_t q;
    fsk_pkg::dev_state_t d;

    // symbol bits that take part for the configured level count
    function automatic logic [2:0] level_mask(input logic [1:0] lvl);
        unique case (lvl)
            `LEVEL_FOUR:  level_mask = 3'h3;
            `LEVEL_EIGHT: level_mask = 3'h7;
            default:      level_mask = 3'h1;
        endcase
    endfunction : level_mask

    always_comb begin
        logic              frame_s;
        logic              ws_s;
        logic              prof;
        logic              en;
        logic [2:0]        mask;
        logic [5:0]        addr;
        logic [15:0]       wd;
        fsk_pkg::mode_t    mode;
        logic [15:0]       sel;
        frame_s = 1'b0;
        ws_s    = 1'b0;
        prof    = 1'b0;
        en      = 1'b0;
        mask    = 3'h0;
        addr    = 6'h00;
        wd      = 16'h0000;
        mode    = fsk_pkg::MODE_PIN;
        sel     = 16'h0000;
        d = q;
        d.pin_m = {link.frame_n, link.serial_data, link.symbol_pin_2,
                   link.symbol_pin_1, link.symbol_pin_0};
        d.pin_s = q.pin_m;
        frame_s = q.pin_s[4];
        ws_s    = q.pin_s[0];
        d.frame_prev = frame_s;
        d.ws_prev    = ws_s;

        // register frame: shift while frame_n low, commit on its rise
        if (!frame_s) begin
            d.shift = {q.shift[22:0], q.pin_s[3]};
            if (q.bitcnt != 5'h1f)
                d.bitcnt = q.bitcnt + 5'h01;
        end else if (!q.frame_prev) begin
            d.bitcnt = 5'h00;
            if (q.bitcnt == `FRAME_BITS) begin
                addr = q.shift[21:16];
                wd   = q.shift[15:0];
                unique case (addr)
                    `DEV_CFG_IDX:      d.cfg = wd;
                    `DEV_INDEX_IDX:    d.index = wd[2:0];       // see [R8]
                    `DEV_FAST_IDX:     d.fast = wd;             // see [R11]
                    `DEV_NOM_A_LO_IDX: d.nom[0][15:0] = wd;
                    `DEV_NOM_A_HI_IDX: d.nom[0][23:16] = wd[7:0];
                    `DEV_NOM_B_LO_IDX: d.nom[1][15:0] = wd;
                    `DEV_NOM_B_HI_IDX: d.nom[1][23:16] = wd[7:0];
                    default: begin
                        // two banks of eight entries each
                        if (addr[5:3] == `DEV_ENTRY_A_GRP)
                            d.entry[0][addr[2:0]] = wd;         // see [R4]
                        else if (addr[5:3] == `DEV_ENTRY_B_GRP)
                            d.entry[1][addr[2:0]] = wd;         // see [R4]
                    end
                endcase
            end
        end

        mode = fsk_pkg::mode_t'({q.cfg[`CFG_SEL_HI], q.cfg[`CFG_SEL_LO]});

        // stream: pin 0 frames a word, pin 1 carries it msb first
        if (mode == fsk_pkg::MODE_STREAM) begin
            if (ws_s)
                d.sshift = {q.sshift[14:0], q.pin_s[1]};        // see [R13]
            else if (q.ws_prev)
                d.stream = q.sshift;                            // see [R13]
        end

        prof = q.cfg[`CFG_PROFILE];                             // see [R14] [R15]
        en   = prof ? q.cfg[`CFG_EN_B] : q.cfg[`CFG_EN_A];
        mask = level_mask(q.cfg[`CFG_LEVEL_MSB:`CFG_LEVEL_LSB]); // see [R5] [R9]
        unique case (mode)
            fsk_pkg::MODE_PIN:    sel = q.entry[prof][q.pin_s[2:0] & mask]; // see [R5] [R6]
            fsk_pkg::MODE_INDEX:  sel = q.entry[prof][q.index & mask];      // see [R7] [R8]
            fsk_pkg::MODE_STREAM: sel = q.stream;               // see [R10] [R13]
            fsk_pkg::MODE_FAST:   sel = q.fast;                 // see [R10] [R12]
        endcase
        d.dev = en ? sel : 16'h0000;                            // see [R17]
        // signed step added to the nominal numerator
        d.numer = q.nom[prof] + {{8{d.dev[15]}}, d.dev};        // see [R1] [R3] [R16]
    end

    always_ff @(posedge link.link_clk) begin
        if (!aresetn) begin
            q        <= '0;
            q.pin_m  <= 5'h10;
            q.pin_s  <= 5'h10;
            q.frame_prev <= 1'b1;
            q.cfg    <= `CFG_RESET;
        end else begin
            q <= d;
        end
    end

    assign frac_numerator = q.numer;
    assign deviation_step = q.dev;
    assign active_profile = q.cfg[`CFG_PROFILE];

endmodule : fsk_deviation_selector
`default_nettype wire

// ==== hdl/fsk_baseband_ctrl.sv ====
// controller end: axi4-lite registers, link clock divider and serial engine
`include "fsk_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fsk_baseband_ctrl (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [3:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [3:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    fsk_link_if.ctrl          link
);

    fsk_pkg::ctl_state_t q;
    fsk_pkg::ctl_state_t d;

    logic busy;
    assign busy = q.pend || (q.state != fsk_pkg::ENG_IDLE);

    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready  = !q.w_have && !q.bvalid;
    assign s_axi_arready = !q.rvalid;

    always_comb begin
        logic [3:0]  wa;
        logic        fall;
        wa   = 4'h0;
        fall = 1'b0;
        d = q;

        // axi write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
        end
        if (q.aw_have && q.w_have) begin
            wa = {q.awaddr[3:2], 2'h0};
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'h0;
            unique case (wa)
                `CTL_CMD_OFS: begin
                    // a command while busy is dropped
                    if (!busy && (&s_axi_wstrb[2:0] || 1'b1)) begin
                        d.pend      = 1'b1;
                        d.is_stream = 1'b0;
                        d.shift     = {2'h0, q.wdata[21:0]};
                        d.last_cmd  = q.wdata[21:0];
                    end
                end
                `CTL_SYM_OFS:    d.sym = q.wdata[2:0];
                `CTL_STREAM_OFS: begin
                    if (!busy) begin
                        d.pend      = 1'b1;
                        d.is_stream = 1'b1;
                        d.shift     = {q.wdata[15:0], 8'h00};   // see [R3] [R16]
                    end
                end
                default: d.bresp = 2'h2;
            endcase
        end
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;

        // axi read
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            unique case ({s_axi_araddr[3:2], 2'h0})
                `CTL_CMD_OFS:    d.rdata = {10'h000, q.last_cmd};
                `CTL_SYM_OFS:    d.rdata = {29'h00000000, q.sym};
                `CTL_STATUS_OFS: d.rdata = {31'h00000000, busy};
                default:         d.rdata = 32'h00000000;
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // link clock is aclk divided by two; frame, data and word select move on its falling edge, symbol pins on the aclk edge after a symbol register write
        d.link_clk = !q.link_clk;
        fall = q.link_clk;
        if (fall) begin
            unique case (q.state)
                fsk_pkg::ENG_IDLE: begin
                    if (q.pend) begin
                        d.pend    = 1'b0;
                        d.state   = fsk_pkg::ENG_SHIFT;
                        d.sdata   = q.shift[23];
                        d.frame_n = q.is_stream;
                        d.ws      = q.is_stream;                // see [R13]
                        d.cnt     = q.is_stream ? `STREAM_BITS : `FRAME_BITS;
                    end
                end
                fsk_pkg::ENG_SHIFT: begin
                    if (q.cnt == 5'h01) begin
                        d.state   = fsk_pkg::ENG_END;
                        d.frame_n = 1'b1;
                        d.ws      = 1'b0;
                        d.sdata   = 1'b0;
                    end else begin
                        d.cnt   = q.cnt - 5'h01;
                        d.shift = {q.shift[22:0], 1'b0};
                        d.sdata = q.shift[22];
                    end
                end
                fsk_pkg::ENG_END: d.state = fsk_pkg::ENG_IDLE;
                default:          d.state = fsk_pkg::ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.frame_n <= 1'b1;
            q.state   <= fsk_pkg::ENG_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp  = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata  = q.rdata;
    assign s_axi_rresp  = 2'h0;

    // stream borrows pin 0 as word select and pin 1 as data
    assign link.link_clk     = q.link_clk;
    assign link.frame_n      = q.frame_n;
    assign link.serial_data  = q.is_stream ? 1'b0 : q.sdata;
    assign link.symbol_pin_0 = q.ws ? 1'b1 : q.sym[0];           // see [R6]
    assign link.symbol_pin_1 = q.ws ? q.sdata : q.sym[1];        // see [R13]
    assign link.symbol_pin_2 = q.sym[2];

endmodule : fsk_baseband_ctrl
`default_nettype wire

// ==== tb/fsk_link_properties.sv ====
// wire-level checks on the link between controller and device
`timescale 1ns/1ps
`default_nettype none
module fsk_link_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    input wire logic frame_n,
    input wire logic serial_data,
    input wire logic symbol_pin_0,
    input wire logic symbol_pin_1,
    input wire logic symbol_pin_2
);
    logic [7:0] low_cnt_q;

    // aclk edges seen with the frame strobe low
    always_ff @(posedge aclk) begin
        if (!aresetn || frame_n) begin
            low_cnt_q <= 8'h00;
        end else begin
            low_cnt_q <= low_cnt_q + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> frame_n && !link_clk)
        else $error("link not idle after reset");
    clk_toggle_a: assert property ($past(aresetn) |-> link_clk != $past(link_clk))
        else $error("link clock stalled");
    frame_len_a: assert property ($rose(frame_n) |-> low_cnt_q == 8'h30)
        else $error("frame not 24 link periods");
    frame_max_a: assert property (!frame_n |-> low_cnt_q < 8'h30)
        else $error("frame too long");
    data_edge_a: assert property (!frame_n && $changed(serial_data) |-> $fell(link_clk))
        else $error("data changed off falling edge");
    frame_edge_a: assert property ($changed(frame_n) |-> $fell(link_clk))
        else $error("frame edge off falling edge");
    spare_bits_a: assert property ($fell(frame_n) |-> !serial_data [*4])
        else $error("spare bits not zero");
    frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*2])
        else $error("no idle period after frame");

    cover property ($rose(frame_n));
    cover property ($rose(symbol_pin_0) && !frame_n);
    cover property ($rose(symbol_pin_2));
    cover property ($rose(symbol_pin_1));
endmodule : fsk_link_properties
`default_nettype wire

// ==== tb/fsk_deviation_selector_tb_top.sv ====
// bench joining controller and device, driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module fsk_deviation_selector_tb_top;
    localparam logic [23:0] NOM_A = 24'h100000;
    localparam logic [23:0] NOM_B = 24'h200000;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        dev_rstn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [3:0]  araddr = 4'h0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, prof;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd;
    logic [23:0] frac;
    logic [15:0] dstep;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #12.5 aclk = ~aclk;

    fsk_link_if i_fsk_link_if ();
    fsk_baseband_ctrl i_fsk_baseband_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(i_fsk_link_if.ctrl));
    fsk_deviation_selector i_fsk_deviation_selector (.link(i_fsk_link_if.dev),
        .aresetn(dev_rstn), .frac_numerator(frac), .deviation_step(dstep),
        .active_profile(prof));
    fsk_link_properties i_fsk_link_properties (.aclk(aclk), .aresetn(aresetn),
        .link_clk(i_fsk_link_if.link_clk), .frame_n(i_fsk_link_if.frame_n),
        .serial_data(i_fsk_link_if.serial_data),
        .symbol_pin_0(i_fsk_link_if.symbol_pin_0),
        .symbol_pin_1(i_fsk_link_if.symbol_pin_1),
        .symbol_pin_2(i_fsk_link_if.symbol_pin_2));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, 2'h0);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        check(rresp, 2'h0);
    endtask : axi_read

    // write, wait for the link engine to go idle, then let the device settle
    task automatic xfer(input logic [3:0] a, input logic [31:0] d);
        axi_write(a, d);
        do axi_read(4'hc, rd); while (rd[0] !== 1'b0);
        repeat (16) @(posedge aclk);
    endtask : xfer

    task automatic cmd(input logic [5:0] idx, input logic [15:0] d);
        xfer(4'h0, {10'h000, idx, d});
    endtask : cmd

    function automatic logic [15:0] ent(input logic p, input int i);
        logic [15:0] v;
        // positive counts for entries 0..3, two's complement for 4..7 in profile 0 only (profile 1 adds 0x100, so all positive)
        v = (i < 4) ? 16'(i + 1) * 16'h0010 : 16'h0000 - 16'(i - 3) * 16'h0010;
        return v + (p ? 16'h0100 : 16'h0000);
    endfunction : ent

    task automatic expect_out(input logic [23:0] n, input logic [15:0] d, input logic p);
        check(dstep, d);
        check(frac, 24'(n + {{8{d[15]}}, d}));
        check(prof, p);
    endtask : expect_out

    task final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            final_report;
        end
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        dev_rstn <= 1'b1;
        repeat (4) @(posedge aclk);
        expect_out(24'h000000, 16'h0000, 1'b0);
        cmd(6'h03, 16'h0000);
        cmd(6'h04, 16'h0010);
        cmd(6'h05, 16'h0000);
        cmd(6'h06, 16'h0020);
        for (int i = 0; i < 8; i++) begin
            cmd(6'h08 + 6'(i), ent(1'b0, i));
            cmd(6'h10 + 6'(i), ent(1'b1, i));
        end
        cmd(6'h00, 16'h000d);
        expect_out(NOM_A, 16'h0000, 1'b0);
        cmd(6'h00, 16'h001d);
        for (int i = 0; i < 8; i++) begin
            cmd(6'h01, 16'(i));
            expect_out(NOM_A, ent(1'b0, i), 1'b0);
        end
        cmd(6'h00, 16'h0018);
        for (int i = 0; i < 4; i++) begin
            xfer(4'h4, 32'(i));
            expect_out(NOM_A, ent(1'b0, i), 1'b0);
        end
        xfer(4'h4, 32'h0000_0006);
        expect_out(NOM_A, ent(1'b0, 2), 1'b0);
        cmd(6'h00, 16'h001c);
        xfer(4'h4, 32'h0000_0007);
        expect_out(NOM_A, ent(1'b0, 7), 1'b0);
        cmd(6'h00, 16'h0013);
        cmd(6'h02, 16'h0206);
        expect_out(NOM_A, 16'h0206, 1'b0);
        cmd(6'h02, 16'hfab2);
        expect_out(NOM_A, 16'hfab2, 1'b0);
        xfer(4'h8, 32'h0000_1234);
        expect_out(NOM_A, 16'hfab2, 1'b0);
        // pin 0 doubles as word select: park it low before entering stream mode
        xfer(4'h4, 32'h0000_0000);
        cmd(6'h00, 16'h0012);
        xfer(4'h8, 32'h0000_f971);
        expect_out(NOM_A, 16'hf971, 1'b0);
        cmd(6'h00, 16'h006d);
        cmd(6'h01, 16'h0005);
        expect_out(NOM_B, ent(1'b1, 5), 1'b1);
        axi_read(4'h0, rd);
        check(rd[21:0], {6'h01, 16'h0005});
        final_report;
    end
endmodule : fsk_deviation_selector_tb_top
`default_nettype wire
